//--- bm_pkg.sv
package bm_pkg;
  // ==========================
  // Register offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h30;
  localparam logic [7:0] OFS_CTRL2 = 8'h34;
  localparam logic [7:0] OFS_LOC = 8'h38;
  localparam logic [7:0] OFS_REM = 8'h3C;
  localparam logic [7:0] OFS_CNT = 8'h40;
  localparam logic [7:0] OFS_TBL = 8'h44;
  localparam logic [7:0] OFS_STAT = 8'h48;
  localparam logic [7:0] OFS_TIMER = 8'h4C;
  // ==========================
  // Primary control fields
  localparam int LVL_LSB = 0;
  localparam int REL_LSB = 2;
  localparam int FAIR_BIT = 4;
  localparam int CHAIN_BIT = 5;
  localparam int GO_BIT = 6;
  localparam int HALT_BIT = 7;
  // ==========================
  // Secondary control fields
  localparam int AM_LSB = 0;
  localparam int D16_BIT = 8;
  localparam int DIR_BIT = 9;
  localparam int LOC_INC_BIT = 10;
  localparam int REM_INC_BIT = 11;
  localparam int PKT_IRQ_BIT = 15;
  localparam logic [15:0] CTRL2_KEEP = 16'hEFFF;
  localparam logic [15:0] CTRL2_SWMASK = 16'h6FFF;
  // ==========================
  // Status fields
  localparam int DONE_BIT = 0;
  localparam int ERR_BIT = 1;
  localparam int BUSY_BIT = 2;
  localparam int ICNT_LSB = 8;
  // ==========================
  // Reset values and sizes
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  localparam logic [1:0] LEVEL_RST = 2'h3;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [2:0] LAST_WORD = 3'h4;
  localparam logic [2:0] BUF_FULL = 3'h4;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_FETCH = 7'b0000010,
    ST_LFILL = 7'b0000100,
    ST_ARB = 7'b0001000,
    ST_VXFER = 7'b0010000,
    ST_LDRAIN = 7'b0100000,
    ST_CMDEND = 7'b1000000
  } bm_state_e;
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bm_loc_s;
  typedef struct packed {
    logic strobe;
    logic write;
    logic d16;
    logic [5:0] am;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bm_rem_s;
endpackage : bm_pkg

//--- bm_block_mover.sv
`timescale 1ns/1ps
`default_nettype none
module bm_block_mover (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output var bm_pkg::bm_loc_s locOut,
  input wire logic locAck,
  input wire logic locErr,
  input wire logic [31:0] locRdata,
  output var bm_pkg::bm_rem_s remOut,
  input wire logic remAck,
  input wire logic remErr,
  input wire logic [31:0] remRdata,
  output logic [3:0] busReq,
  output logic busBusy,
  input wire logic busGrant,
  input wire logic [3:0] busReqSeen,
  output logic irqReq
);
  // ==========================
  // Helpers
  function automatic logic [31:0] adv(input logic [31:0] a, input logic inc, input logic [2:0] s);
    adv = inc ? a + {29'h0, s} : a;
  endfunction : adv

  function automatic logic [3:0] oneHot(input logic [1:0] l);
    oneHot = 4'h1 << l;
  endfunction : oneHot

  function automatic logic relOf(input logic [1:0] m, input logic exp, input logic br);
    case (m)
      2'h0: relOf = exp & br;
      2'h1: relOf = exp;
      2'h2: relOf = br;
      default: relOf = exp | br;
    endcase
  endfunction : relOf

  bm_pkg::bm_state_e state;
  logic [7:0] ctrl1;
  logic [15:0] ctrl2;
  logic [31:0] locAddr, remAddr, byteCnt, tblAddr, nextPtr;
  logic [15:0] timers;
  logic stDone, stErr, waitLow, wPend;
  logic [3:0] irqCnt;
  logic [2:0] fetchIdx, bufCnt, step;
  logic [31:0] bufMem [0:3];
  logic [2:0] stepMem [0:3];
  logic [1:0] wrIdx, rdIdx, curLevel;
  logic [7:0] wAddr, onCnt, offCnt;
  // Two flops on every far-side pin except the local ack, error and read data
  logic [3:0] brS1, brS2;
  logic grS1, grS2, ackS1, ackS2, errS1, errS2;
  logic [31:0] rdS1, rdS2, rdVal;
  logic locHit, remHit, fault, relNow, wantBus, idle, goWrite;

  // ==========================
  // Pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {brS1, grS1, ackS1, errS1, rdS1} <= '0;
      {brS2, grS2, ackS2, errS2, rdS2} <= '0;
    end else if (clkEn) begin
      {brS1, grS1, ackS1, errS1, rdS1} <= {busReqSeen, busGrant, remAck, remErr, remRdata};
      {brS2, grS2, ackS2, errS2, rdS2} <= {brS1, grS1, ackS1, errS1, rdS1};
    end
  end

  // ==========================
  // Event decode
  always_comb begin
    step = byteCnt < (ctrl2[bm_pkg::D16_BIT] ? 32'h2 : 32'h4) ? byteCnt[2:0] :
      (ctrl2[bm_pkg::D16_BIT] ? 3'h2 : 3'h4);
    locHit = locOut.req & locAck;
    remHit = remOut.strobe & ackS2 & ~errS2;
    fault = (locHit & locErr) | (remOut.strobe & errS2);
    relNow = relOf(ctrl1[bm_pkg::REL_LSB +: 2], onCnt == 8'h0, |brS2);
    idle = state == bm_pkg::ST_IDLE;
    wantBus = (state == bm_pkg::ST_ARB) | (state == bm_pkg::ST_VXFER);
    goWrite = wPend & (wAddr == bm_pkg::OFS_CTRL1) & hwdata[bm_pkg::GO_BIT];
  end

  // ==========================
  // Register read mux
  always_comb begin
    case (haddr[7:0])
      bm_pkg::OFS_CTRL1: rdVal = {24'h0, ctrl1};
      bm_pkg::OFS_CTRL2: rdVal = {16'h0, ctrl2};
      bm_pkg::OFS_LOC: rdVal = locAddr;
      bm_pkg::OFS_REM: rdVal = remAddr;
      bm_pkg::OFS_CNT: rdVal = byteCnt;
      bm_pkg::OFS_TBL: rdVal = tblAddr;
      bm_pkg::OFS_STAT: rdVal = {20'h0, irqCnt, 5'h0, ~idle, stErr, stDone};
      bm_pkg::OFS_TIMER: rdVal = {16'h0, timers};
      default: rdVal = 32'h0;
    endcase
  end

  // ==========================
  // AHB-Lite slave, zero wait
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wPend <= 1'b0;
      wAddr <= 8'h0;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wPend <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wPend <= hwrite;
        wAddr <= haddr[7:0];
        hrdata <= hwrite ? 32'h0 : rdVal;
      end
    end
  end

  // ==========================
  // VMEbus requester
  // Level latched at grant, so a change shows only from the request after next
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      curLevel <= bm_pkg::LEVEL_RST;
      busReq <= 4'h0;
      busBusy <= 1'b0;
      onCnt <= 8'h0;
      offCnt <= 8'h0;
    end else if (clkEn) begin
      if (busBusy) begin
        if (onCnt != 8'h0) begin
          onCnt <= onCnt - 8'h1;
        end
        if (state != bm_pkg::ST_VXFER) begin
          busBusy <= 1'b0;
          offCnt <= timers[15:8];
        end
      end else if (busReq != 4'h0) begin
        if (grS2) begin
          busReq <= 4'h0;
          busBusy <= 1'b1;
          curLevel <= ctrl1[bm_pkg::LVL_LSB +: 2];
          onCnt <= timers[7:0];
        end
      end else if (offCnt != 8'h0) begin
        offCnt <= offCnt - 8'h1;
      // Stale synced grant must clear before a new request
      end else if (wantBus && !grS2 && !(ctrl1[bm_pkg::FAIR_BIT] && brS2[curLevel])) begin
        busReq <= oneHot(curLevel);
      end
    end
  end

  // ==========================
  // Engine, counters and status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= bm_pkg::ST_IDLE;
      ctrl1 <= bm_pkg::CTRL1_RST;
      ctrl2 <= bm_pkg::CTRL2_RST;
      locAddr <= 32'h0;
      remAddr <= 32'h0;
      byteCnt <= 32'h0;
      tblAddr <= 32'h0;
      nextPtr <= 32'h0;
      timers <= bm_pkg::TIMER_RST;
      stDone <= 1'b0;
      stErr <= 1'b0;
      irqCnt <= 4'h0;
      irqReq <= 1'b0;
      fetchIdx <= 3'h0;
      bufCnt <= 3'h0;
      wrIdx <= 2'h0;
      rdIdx <= 2'h0;
      waitLow <= 1'b0;
      locOut <= '0;
      remOut <= '0;
      for (int i = 0; i < 4; i++) begin
        bufMem[i] <= 32'h0;
        stepMem[i] <= 3'h0;
      end
    end else if (clkEn) begin
      irqReq <= 1'b0;
      if (waitLow && !ackS2 && !errS2) begin
        waitLow <= 1'b0;
      end
      if (wPend) begin
        case (wAddr)
          bm_pkg::OFS_CTRL1: ctrl1 <= {hwdata[7], 1'b0, hwdata[5:0]};
          bm_pkg::OFS_CTRL2: if (idle) begin
            ctrl2 <= (ctrl2 & ~bm_pkg::CTRL2_SWMASK) | (hwdata[15:0] & bm_pkg::CTRL2_SWMASK);
          end
          bm_pkg::OFS_LOC: if (idle) begin
            locAddr <= hwdata;
          end
          bm_pkg::OFS_REM: if (idle) begin
            remAddr <= hwdata;
          end
          bm_pkg::OFS_CNT: if (idle) begin
            byteCnt <= hwdata;
          end
          bm_pkg::OFS_TBL: if (idle) begin
            tblAddr <= hwdata;
          end
          bm_pkg::OFS_TIMER: timers <= hwdata[15:0];
          bm_pkg::OFS_STAT: begin
            if (hwdata[bm_pkg::DONE_BIT]) begin
              stDone <= 1'b0;
            end
            if (hwdata[bm_pkg::ERR_BIT]) begin
              stErr <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (fault) begin
        stErr <= 1'b1;
        stDone <= 1'b1;
        irqReq <= 1'b1;
        irqCnt <= irqCnt + 4'h1;
        locOut.req <= 1'b0;
        remOut.strobe <= 1'b0;
        waitLow <= remOut.strobe;
        bufCnt <= 3'h0;
        state <= bm_pkg::ST_IDLE;
      end else begin
        case (state)
          bm_pkg::ST_IDLE: if (goWrite) begin
            stDone <= 1'b0;
            stErr <= 1'b0;
            irqCnt <= 4'h0;
            bufCnt <= 3'h0;
            wrIdx <= 2'h0;
            rdIdx <= 2'h0;
            fetchIdx <= 3'h0;
            if (hwdata[bm_pkg::CHAIN_BIT]) begin
              state <= bm_pkg::ST_FETCH;
            end else if (byteCnt == 32'h0) begin
              state <= bm_pkg::ST_CMDEND;
            end else begin
              state <= ctrl2[bm_pkg::DIR_BIT] ? bm_pkg::ST_LFILL : bm_pkg::ST_ARB;
            end
          end
          bm_pkg::ST_FETCH: if (locHit) begin
            locOut.req <= 1'b0;
            case (fetchIdx)
              3'h0: ctrl2 <= locRdata[15:0] & bm_pkg::CTRL2_KEEP;
              3'h1: locAddr <= locRdata;
              3'h2: remAddr <= locRdata;
              3'h3: byteCnt <= locRdata;
              default: nextPtr <= locRdata;
            endcase
            fetchIdx <= fetchIdx + 3'h1;
            if (fetchIdx == bm_pkg::LAST_WORD) begin
              fetchIdx <= 3'h0;
              if (byteCnt == 32'h0) begin
                state <= bm_pkg::ST_CMDEND;
              end else begin
                state <= ctrl2[bm_pkg::DIR_BIT] ? bm_pkg::ST_LFILL : bm_pkg::ST_ARB;
              end
            end
          end else if (!locOut.req) begin
            locOut.req <= 1'b1;
            locOut.write <= 1'b0;
            locOut.addr <= tblAddr + {27'h0, fetchIdx, 2'h0};
          end
          bm_pkg::ST_LFILL: if (locHit) begin
            locOut.req <= 1'b0;
            bufMem[wrIdx] <= locRdata;
            stepMem[wrIdx] <= step;
            wrIdx <= wrIdx + 2'h1;
            bufCnt <= bufCnt + 3'h1;
            byteCnt <= byteCnt - {29'h0, step};
            locAddr <= adv(locAddr, ctrl2[bm_pkg::LOC_INC_BIT], step);
            if (bufCnt == bm_pkg::BUF_FULL - 3'h1 || byteCnt == {29'h0, step}) begin
              state <= bm_pkg::ST_ARB;
            end
          end else if (!locOut.req) begin
            locOut.req <= 1'b1;
            locOut.write <= 1'b0;
            locOut.addr <= locAddr;
          end
          bm_pkg::ST_ARB: if (busReq != 4'h0 && grS2) begin
            state <= bm_pkg::ST_VXFER;
          end
          bm_pkg::ST_VXFER: if (remHit) begin
            remOut.strobe <= 1'b0;
            waitLow <= 1'b1;
            if (remOut.write) begin
              remAddr <= adv(remAddr, ctrl2[bm_pkg::REM_INC_BIT], stepMem[rdIdx]);
              rdIdx <= rdIdx + 2'h1;
              bufCnt <= bufCnt - 3'h1;
              // Empty buffer always ends the tenure
              if (bufCnt == 3'h1) begin
                state <= byteCnt != 32'h0 ? bm_pkg::ST_LFILL : bm_pkg::ST_CMDEND;
              end else if (relNow) begin
                state <= bm_pkg::ST_ARB;
              end
            end else begin
              bufMem[wrIdx] <= rdS2;
              stepMem[wrIdx] <= step;
              wrIdx <= wrIdx + 2'h1;
              bufCnt <= bufCnt + 3'h1;
              byteCnt <= byteCnt - {29'h0, step};
              remAddr <= adv(remAddr, ctrl2[bm_pkg::REM_INC_BIT], step);
              if (bufCnt == bm_pkg::BUF_FULL - 3'h1 || byteCnt == {29'h0, step} || relNow) begin
                state <= bm_pkg::ST_LDRAIN;
              end
            end
          end else if (!remOut.strobe && !waitLow) begin
            remOut.strobe <= 1'b1;
            remOut.write <= ctrl2[bm_pkg::DIR_BIT];
            remOut.d16 <= ctrl2[bm_pkg::D16_BIT];
            remOut.am <= ctrl2[bm_pkg::AM_LSB +: 6];
            remOut.addr <= remAddr;
            remOut.wdata <= bufMem[rdIdx];
          end
          bm_pkg::ST_LDRAIN: if (locHit) begin
            locOut.req <= 1'b0;
            locAddr <= adv(locAddr, ctrl2[bm_pkg::LOC_INC_BIT], stepMem[rdIdx]);
            rdIdx <= rdIdx + 2'h1;
            bufCnt <= bufCnt - 3'h1;
            if (bufCnt == 3'h1) begin
              state <= byteCnt != 32'h0 ? bm_pkg::ST_ARB : bm_pkg::ST_CMDEND;
            end
          end else if (!locOut.req) begin
            locOut.req <= 1'b1;
            locOut.write <= 1'b1;
            locOut.addr <= locAddr;
            locOut.wdata <= bufMem[rdIdx];
          end
          bm_pkg::ST_CMDEND: begin
            // One pulse covers both packet and final interrupt
            if (ctrl1[bm_pkg::CHAIN_BIT] && ctrl2[bm_pkg::PKT_IRQ_BIT]) begin
              irqReq <= 1'b1;
              irqCnt <= irqCnt + 4'h1;
            end
            if (!ctrl1[bm_pkg::CHAIN_BIT] || ctrl1[bm_pkg::HALT_BIT] || nextPtr[1:0] != 2'h0) begin
              stDone <= 1'b1;
              irqReq <= 1'b1;
              irqCnt <= irqCnt + 4'h1;
              state <= bm_pkg::ST_IDLE;
            end else begin
              tblAddr <= nextPtr;
              state <= bm_pkg::ST_FETCH;
            end
          end
          default: state <= bm_pkg::ST_IDLE;
        endcase
      end
    end
  end
endmodule : bm_block_mover
`default_nettype wire

//--- bm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checks for the block mover
module bm_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire bm_pkg::bm_loc_s locOut,
  input wire logic locAck,
  input wire bm_pkg::bm_rem_s remOut,
  input wire logic remAck,
  input wire logic [3:0] busReq,
  input wire logic busBusy,
  input wire logic irqReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic rdCtl1;
  logic seenReq;
  // Data phase of a primary control read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) rdCtl1 <= 1'b0;
    else if (hready) rdCtl1 <= hsel && htrans[1] && !hwrite && haddr[7:0] == bm_pkg::OFS_CTRL1;
  end
  // Only the very first request after reset is pinned
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) seenReq <= 1'b0;
    else seenReq <= seenReq || (|busReq);
  end
  sequence s_locWait;
    locOut.req && !locAck;
  endsequence
  sequence s_remWait;
    remOut.strobe && !remAck;
  endsequence
  sequence s_remAcked;
    $rose(remAck) && remOut.strobe;
  endsequence
  a_go_reads_zero: assert property (rdCtl1 |-> !hrdata[6])
    else $error("start bit read back as one");
  a_first_level: assert property (!seenReq && (|busReq) |-> busReq == 4'h8)
    else $error("first request not on level 3");
  a_req_onehot: assert property ($onehot0(busReq))
    else $error("more than one request level driven");
  a_master_no_req: assert property (busBusy |-> busReq == 4'h0)
    else $error("request held while master");
  a_loc_hold: assert property (s_locWait |=> locOut.req && $stable(locOut.addr) && $stable(locOut.write))
    else $error("local request changed before acknowledge");
  a_loc_drop: assert property (locAck |=> !locOut.req)
    else $error("local request not dropped after acknowledge");
  a_rem_hold: assert property (s_remWait |=> remOut.strobe && $stable(remOut.addr))
    else $error("remote strobe changed before acknowledge");
  a_rem_release: assert property (s_remAcked |-> ##[1:6] !remOut.strobe)
    else $error("remote strobe not released after acknowledge");
  a_rem_master: assert property (remOut.strobe |-> busBusy)
    else $error("remote cycle without bus ownership");
  a_irq_pulse: assert property (irqReq |=> !irqReq)
    else $error("interrupt request longer than one cycle");
endmodule : bm_checker
bind bm_block_mover bm_checker i_chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .locOut(locOut), .locAck(locAck), .remOut(remOut), .remAck(remAck),
  .busReq(busReq), .busBusy(busBusy), .irqReq(irqReq));
`default_nettype wire

//--- bm_far.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Far side: local memory, remote memory, arbiter
module bm_far (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic errOn,
  input wire bm_pkg::bm_loc_s locOut,
  output logic locAck,
  output logic locErr,
  output logic [31:0] locRdata,
  input wire bm_pkg::bm_rem_s remOut,
  output logic remAck,
  output logic remErr,
  output logic [31:0] remRdata,
  input wire logic [3:0] busReq,
  input wire logic busBusy,
  output logic busGrant
);
  logic [31:0] locMem [0:63];
  logic [31:0] remMem [0:63];
  logic slow;
  // Wait flag set after even words clears in the acknowledge cycle, so all answers are prompt
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      locAck <= 1'b0;
      locErr <= 1'b0;
      locRdata <= 32'h0;
      slow <= 1'b0;
    end else if (locOut.req && !locAck && !slow) begin
      locAck <= 1'b1;
      slow <= ~locOut.addr[2];
      locRdata <= locMem[locOut.addr[7:2]];
      if (locOut.write) locMem[locOut.addr[7:2]] <= locOut.wdata;
    end else begin
      locAck <= 1'b0;
      if (locOut.req) slow <= 1'b0;
      locRdata <= ~locRdata;
    end
  end
  // Four-phase answer; data inverted while no cycle stands
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remAck <= 1'b0;
      remErr <= 1'b0;
      remRdata <= 32'h0;
    end else if (remOut.strobe && !remAck) begin
      remAck <= 1'b1;
      remErr <= errOn;
      remRdata <= remMem[remOut.addr[7:2]];
      if (remOut.write && !errOn) remMem[remOut.addr[7:2]] <= remOut.wdata;
    end else if (!remOut.strobe) begin
      remAck <= 1'b0;
      remErr <= 1'b0;
      remRdata <= ~remRdata;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) busGrant <= 1'b0;
    else busGrant <= (|busReq) || (busGrant && busBusy);
  end
endmodule : bm_far
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Register level scenarios
module tb;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp, locAck, locErr;
  logic remAck, remErr, busBusy, busGrant, irqReq, errOn, lastD16, prevBusy;
  logic [31:0] haddr, hwdata, hrdata, locRdata, remRdata;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [3:0] busReq, busReqSeen, firstReq;
  logic [31:0] pk [0:9];
  bm_pkg::bm_loc_s locOut;
  bm_pkg::bm_rem_s remOut;
  int irqN, errorCnt, testsRun, tenN;
  bm_block_mover i_dut (.core_clk(core_clk), .rst(rst), .clkEn(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .locOut(locOut), .locAck(locAck), .locErr(locErr), .locRdata(locRdata),
    .remOut(remOut), .remAck(remAck), .remErr(remErr), .remRdata(remRdata),
    .busReq(busReq), .busBusy(busBusy), .busGrant(busGrant), .busReqSeen(busReqSeen),
    .irqReq(irqReq));
  bm_far i_far (.core_clk(core_clk), .rst(rst), .errOn(errOn), .locOut(locOut),
    .locAck(locAck), .locErr(locErr), .locRdata(locRdata), .remOut(remOut),
    .remAck(remAck), .remErr(remErr), .remRdata(remRdata), .busReq(busReq),
    .busBusy(busBusy), .busGrant(busGrant));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (irqReq === 1'b1) irqN <= irqN + 1;
    if (firstReq === 4'h0 && busReq !== 4'h0) firstReq <= busReq;
    if (remOut.strobe === 1'b1) lastD16 <= remOut.d16;
    prevBusy <= busBusy;
    if (busBusy === 1'b1 && prevBusy === 1'b0) tenN <= tenN + 1;
  end
  task wrapUp;
    if (errorCnt == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrapUp
  task chk(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Bounded wait on hready; a hang ends the run
  task waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errorCnt++;
      wrapUp;
    end
  endtask : waitRdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    q = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rc
  task waitDone;
    logic [31:0] v;
    int n;
    n = 0;
    v = 32'h0;
    while (v[0] !== 1'b1 && n < 400) begin
      xfer(1'b0, bm_pkg::OFS_STAT, 32'h0, v);
      n++;
    end
    if (v[0] !== 1'b1) begin
      errorCnt++;
      wrapUp;
    end
  endtask : waitDone
  task go(input logic [31:0] c2, l, r, c, input logic [7:0] c1);
    wr(bm_pkg::OFS_LOC, l);
    wr(bm_pkg::OFS_REM, r);
    wr(bm_pkg::OFS_CNT, c);
    wr(bm_pkg::OFS_CTRL2, c2);
    irqN = 0;
    tenN = 0;
    firstReq = 4'h0;
    wr(bm_pkg::OFS_CTRL1, {24'h0, c1});
  endtask : go
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, busReqSeen, errOn} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    {errorCnt, testsRun, irqN, tenN, firstReq, lastD16, prevBusy} = '0;
    // Packets: word aligned, last one ends on low pointer bits
    pk = '{32'h8E00, 32'h10, 32'h60, 32'h4, 32'h60, 32'h0E00, 32'h14, 32'h64, 32'h4, 32'h3};
    for (int i = 0; i < 64; i++) begin
      i_far.locMem[i] = 32'hA5000000 + i;
      i_far.remMem[i] = 32'h0;
    end
    for (int i = 0; i < 5; i++) begin
      i_far.locMem[16 + i] = pk[i];
      i_far.locMem[24 + i] = pk[5 + i];
    end
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rc(bm_pkg::OFS_CTRL1, 32'h0);
    rc(bm_pkg::OFS_CTRL2, 32'h0);
    rc(8'h80, 32'h0);
    wr(bm_pkg::OFS_CTRL2, 32'hFFFF);
    rc(bm_pkg::OFS_CTRL2, 32'h6FFF);
    go(32'h0E00, 32'h10, 32'h20, 32'h8, 8'h40);
    waitDone;
    chk(i_far.remMem[8], 32'hA5000004);
    chk(i_far.remMem[9], 32'hA5000005);
    chk({28'h0, firstReq}, 32'h8);
    chk(32'(irqN), 32'h1);
    rc(bm_pkg::OFS_CNT, 32'h0);
    rc(bm_pkg::OFS_LOC, 32'h18);
    rc(bm_pkg::OFS_REM, 32'h28);
    rc(bm_pkg::OFS_CTRL1, 32'h0);
    go(32'h0D00, 32'h08, 32'h30, 32'h4, 8'h40);
    waitDone;
    chk({31'h0, lastD16}, 32'h1);
    rc(bm_pkg::OFS_LOC, 32'h0C);
    rc(bm_pkg::OFS_REM, 32'h34);
    wr(bm_pkg::OFS_TBL, 32'h40);
    go(32'h0, 32'h0, 32'h0, 32'h0, 8'h60);
    waitDone;
    chk(i_far.remMem[24], 32'hA5000004);
    chk(i_far.remMem[25], 32'hA5000005);
    chk(32'(irqN), 32'h2);
    rc(bm_pkg::OFS_TBL, 32'h60);
    rc(bm_pkg::OFS_CTRL1, 32'h20);
    rc(bm_pkg::OFS_CTRL2, 32'h0E00);
    rc(bm_pkg::OFS_STAT, 32'h0201);
    i_far.remMem[25] = 32'h0;
    wr(bm_pkg::OFS_TBL, 32'h40);
    go(32'h0, 32'h0, 32'h0, 32'h0, 8'hE0);
    waitDone;
    rc(bm_pkg::OFS_TBL, 32'h40);
    chk(i_far.remMem[25], 32'h0);
    chk(32'(irqN), 32'h1);
    // Level written now shows only on the request after next
    for (int l = 1; l < 4; l++) begin
      go(32'h0600, 32'h10, 32'h20, 32'h4, 8'h40 | 8'(l << 2) | 8'(l));
      waitDone;
      chk({28'h0, firstReq}, 32'h1 << (l - 1));
      rc(bm_pkg::OFS_REM, 32'h20);
    end
    busReqSeen <= 4'h8;
    go(32'h0E00, 32'h10, 32'h20, 32'h4, 8'h53);
    wr(bm_pkg::OFS_CNT, 32'h99);
    repeat (20) @(posedge core_clk);
    chk({28'h0, firstReq}, 32'h0);
    busReqSeen <= 4'h0;
    waitDone;
    chk({28'h0, firstReq}, 32'h8);
    rc(bm_pkg::OFS_CNT, 32'h0);
    errOn <= 1'b1;
    go(32'h0E00, 32'h10, 32'h20, 32'h8, 8'h40);
    waitDone;
    errOn <= 1'b0;
    rc(bm_pkg::OFS_STAT, 32'h0103);
    wr(bm_pkg::OFS_STAT, 32'h3);
    rc(bm_pkg::OFS_STAT, 32'h0100);
    // Short time-on splits a two-word write into two tenures
    wr(bm_pkg::OFS_TIMER, 32'h0302);
    go(32'h0E00, 32'h10, 32'h40, 32'h8, 8'h44);
    waitDone;
    chk(i_far.remMem[16], 32'hA5000004);
    chk(i_far.remMem[17], 32'hA5000005);
    chk(32'(tenN), 32'h2);
    wrapUp;
  end
endmodule : tb
`default_nettype wire
